// *** verif/link_sink_model.sv ***
// Far-end sink standing in for the baseband processor on the sample link.
// Assumes the block's registered link outputs and the one shared clock.
`timescale 1ns/1ps
module link_sink_model
	import rx_chain_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire sample_t     link_out,
	input  wire logic        link_valid,
	output logic      [31:0] rx_count,
	output sample_t          last_s
);
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			rx_count <= 32'h0000_0000;
			last_s   <= '0;
		end
		else if (link_valid)
		begin
			rx_count <= rx_count + 32'h0000_0001;
			last_s   <= link_out;
		end
	end
endmodule : link_sink_model

// *** verif/rx_decimation_if_conversion_bench.sv ***
// Self-checking bench of the receive decimation and IF conversion chain.
// Assumes the register map of the package and a sink model on the link side.
`timescale 1ns/1ps
module rx_decimation_if_conversion_bench
	import rx_chain_pkg::*;
	;
	logic        clk;
	logic        reset_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	sample_t     adc_in;
	logic        adc_valid;
	sample_t     link_out;
	logic        link_valid;
	logic [3:0]  link_chan;
	logic        link_real;
	logic [31:0] rx_count;
	sample_t     last_s;
	logic [31:0] rd_v;
	logic [31:0] tot;
	int          bad_count;
	int          n_checks;
	sample_t     want;

	// Reset word of the decimation register and a constant test sample.
	// The sample stays positive and below 1024 so that the divide-by-five gain rounds back to it.
	localparam logic [31:0] D0  = 32'h0000_4AAC;
	localparam logic [31:0] ONE = 32'h0000_0001;
	localparam sample_t     S   = '{i: 16'h0124, q: 16'h03BC};

	////////////////////////////////////////////////////////////////////////////////
	rx_decimation_if_conversion u_dut (
		.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_in(adc_in),
		.adc_valid(adc_valid), .link_out(link_out), .link_valid(link_valid),
		.link_chan(link_chan), .link_real(link_real)
	);

	link_sink_model u_sink (
		.clk(clk), .reset_n(reset_n), .link_out(link_out), .link_valid(link_valid),
		.rx_count(rx_count), .last_s(last_s)
	);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_reg

	task automatic cmp_out(input logic [31:0] got, input logic [31:0] exp);
		cmp_reg(got, exp);
	endtask : cmp_out

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		rd_v = reg_rdata;
	endtask : rd

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	// Settings change only while stopped, then 80 samples are streamed four cycles apart.
	task automatic run_case(input logic [31:0] dec, input logic [31:0] mode,
		input logic [31:0] ctrl, input logic [31:0] exp_n);
		logic [31:0] base;
		sample_t     exp_s;
		wr(ADDR_CTRL, 32'h0000_0000);
		wr(ADDR_DECIM, dec);
		wr(ADDR_MODE, mode);
		wr(ADDR_CTRL, ctrl);
		base = rx_count;
		for (int k = 0; k < 80; k++)
		begin
			@(posedge clk);
			adc_valid <= 1'b1;
			adc_in    <= S;
			@(posedge clk);
			adc_valid <= 1'b0;
			repeat (2) @(posedge clk);
		end
		repeat (100) @(posedge clk);
		#1;
		exp_s = want;
		if (ctrl[POS_REAL])
			exp_s.q = 16'h0000;
		tot = tot + exp_n;
		cmp_out(rx_count - base, exp_n);
		cmp_out({27'h000_0000, link_real, link_chan}, {27'h000_0000, ctrl[POS_REAL], mode[7:4]});
		if (exp_n != 0)
			cmp_out(last_s, exp_s);
	endtask : run_case

	task automatic chk_rate(input logic [31:0] r, input logic [31:0] e);
		wr(ADDR_RATE, r);
		rd(ADDR_STATUS);
		cmp_reg(rd_v & ONE, e);
	endtask : chk_rate

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		reset_n   = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		adc_in    = '0;
		adc_valid = 1'b0;
		tot       = 32'h0000_0000;
		want      = S;
		bad_count = 0;
		n_checks  = 0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		rd(ADDR_DECIM);
		cmp_reg(rd_v, D0);
		rd(ADDR_MODE);
		cmp_reg(rd_v, 32'h0000_0000);
		rd(ADDR_RATE);
		cmp_reg(rd_v, 32'h0000_7800);
		rd(8'h20);
		cmp_reg(rd_v, 32'h0000_0000);
		run_case(D0, 32'h0000_0010, 32'h0000_0001, 32'h0000_0050);
		rd(ADDR_STATUS);
		cmp_reg(rd_v & 32'h0000_003C, 32'h0000_0030);
		run_case(D0 + (ONE << POS_HB1), 32'h0000_0010, ONE, 32'h0000_0028);
		run_case(D0 + (ONE << POS_HB2) + (ONE << POS_HB3), 32'h0000_0010, ONE, 32'h0000_0014);
		run_case(D0 + (ONE << POS_FIRST_FIXED_FIR) + (ONE << POS_SECOND_FIXED_FIR), 32'h0000_0010, ONE, 32'h0000_0014);
		run_case(D0 + ONE, 32'h0000_0010, ONE, 32'h0000_0010);
		rd(ADDR_STATUS);
		cmp_reg(rd_v & 32'h0000_003C, 32'h0000_0034);
		run_case(D0 + (ONE << POS_PROGRAMMABLE_FIR_STAGE), 32'h0000_0010, ONE, 32'h0000_0028);
		run_case(D0 + (32'h0000_0003 << POS_PROGRAMMABLE_FIR_STAGE), 32'h0000_0010, ONE, 32'h0000_0014);
		run_case(D0, 32'h0000_0012, ONE, 32'h0000_00A0);
		run_case(D0, 32'h0000_0011, ONE, 32'h0000_0050);
		run_case(D0, 32'h0000_0013, 32'h0000_0003, 32'h0000_0028);
		run_case(D0, 32'h0000_0012, 32'h0000_0007, 32'h0000_00A0);
		run_case(D0, 32'h0000_0010, 32'h0000_0005, 32'h0000_0050);
		run_case(D0, 32'h0000_0000, ONE, 32'h0000_0000);
		run_case(D0 + (ONE << POS_SECOND_FIXED_FIR), 32'h0000_0050, ONE, 32'h0000_0050);
		// Half-turn first shift, quarter-turn second shift and -6 dB gain: 79 samples end at +1/4.
		wr(ADDR_CTRL, 32'h0000_0000);
		wr(ADDR_SHIFT, 32'h0000_0006);
		wr(ADDR_PROGRAMMABLE_FIR_STAGE, 32'h0000_0002);
		want = '{i: 16'hFE22, q: 16'h0092};
		run_case(D0, 32'h0000_0010, ONE, 32'h0000_0050);
		wr(ADDR_CTRL, 32'h0000_0000);
		wr(ADDR_SHIFT, 32'h0000_0000);
		wr(ADDR_PROGRAMMABLE_FIR_STAGE, 32'h0000_0001);
		want = S;
		run_case(D0, 32'h0000_00A0, ONE, 32'h0000_0050);
		wr(ADDR_MODE, 32'h0000_0000);
		rd(ADDR_MODE);
		cmp_reg(rd_v, 32'h0000_00A0);
		wr(ADDR_CTRL, 32'h0000_0000);
		chk_rate(32'h0005_A001, ONE);
		chk_rate(32'h0005_A000, 32'h0000_0000);
		chk_rate(32'h0000_77FF, ONE);
		wr(ADDR_PROGRAMMABLE_FIR_STAGE, 32'h0000_0008);
		rd(ADDR_STATUS);
		cmp_reg(rd_v & 32'h0000_0002, 32'h0000_0002);
		wr(ADDR_PROGRAMMABLE_FIR_STAGE, 32'h0000_0001);
		rd(ADDR_STATUS);
		cmp_reg(rd_v & 32'h0000_0002, 32'h0000_0000);
		rd(ADDR_COUNT);
		cmp_reg(rd_v, tot);
		give_verdict();
	end

	// The whole run needs about 7,000 cycles; over five times that means a hang.
	initial
	begin
		repeat (40000) @(posedge clk);
		bad_count++;
		give_verdict();
	end
endmodule : rx_decimation_if_conversion_bench

// *** verilog/decim2_stage.sv ***
// One halving filter stage with a sample-valid strobe beside its data.
// Assumes the input strobe never comes in two cycles back to back after the front.
`timescale 1ns/1ps
module decim2_stage
	import rx_chain_pkg::*;
(
	input  wire logic    clk,
	input  wire logic    reset_n,
	input  wire logic    bypass,
	input  wire logic    narrow,
	input  wire sample_t in_s,
	input  wire logic    in_valid,
	output sample_t      out_s,
	output logic         out_valid
);
	sample_t held_q, held_d, out_q, out_d;
	logic    phase_q, phase_d, valid_q, valid_d;

	always_comb
	begin
		held_d  = held_q;
		phase_d = phase_q;
		out_d   = out_q;
		valid_d = 1'b0;
		if (in_valid)
		begin
			if (bypass)
			begin
				out_d   = in_s;
				valid_d = 1'b1;
				phase_d = 1'b0;
			end
			else if (!phase_q)
			begin
				held_d  = in_s;
				phase_d = 1'b1;
			end
			else
			begin
				out_d   = narrow ? avg2(avg2(held_q, in_s), out_q) : avg2(held_q, in_s);
				valid_d = 1'b1;
				phase_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			held_q  <= '0;
			out_q   <= '0;
			phase_q <= 1'b0;
			valid_q <= 1'b0;
		end
		else
		begin
			held_q  <= held_d;
			out_q   <= out_d;
			phase_q <= phase_d;
			valid_q <= valid_d;
		end
	end

	assign out_s     = out_q;
	assign out_valid = valid_q;
endmodule : decim2_stage

// *** verilog/rx_chain_pkg.sv ***
// Shared types, register map and helpers of the receive decimation and IF conversion chain.
// Assumes one clock and a synchronous active-low reset in every user.
package rx_chain_pkg;

	typedef struct packed {
		logic signed [15:0] i;
		logic signed [15:0] q;
	} sample_t;

	typedef enum logic [1:0] {
		IFM_BYPASS = 2'h0,
		IFM_FILTER = 2'h1,
		IFM_INT2   = 2'h2,
		IFM_DEC2   = 2'h3
	} if_mode_t;

	typedef struct packed {
		logic [2:0]  front_sel;
		logic [1:0]  second_fixed_fir_dec;
		logic [1:0]  first_fixed_fir_dec;
		logic [1:0]  hb3_dec;
		logic [1:0]  hb2_dec;
		logic [1:0]  hb1_dec;
		logic        hb1_wide;
		logic [2:0]  programmable_fir_stage_dec;
		logic [1:0]  programmable_fir_stage_gain;
		logic [1:0]  programmable_fir_stage_taps;
		if_mode_t    if_mode;
		logic        real_if;
		logic        dual_band;
		logic [3:0]  chan_sel;
		logic [7:0]  shift_steps;
		logic [19:0] out_rate;
	} cfg_t;

	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_DECIM  = 8'h04;
	localparam logic [7:0] ADDR_MODE   = 8'h08;
	localparam logic [7:0] ADDR_SHIFT  = 8'h0C;
	localparam logic [7:0] ADDR_RATE   = 8'h10;
	localparam logic [7:0] ADDR_PROGRAMMABLE_FIR_STAGE   = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_COUNT  = 8'h1C;

	localparam int POS_RUN = 0, POS_DUAL = 1, POS_REAL = 2;
	localparam int POS_FRONT = 0, POS_SECOND_FIXED_FIR = 3, POS_FIRST_FIXED_FIR = 5, POS_HB3 = 7;
	localparam int POS_HB2 = 9, POS_HB1 = 11, POS_WIDE = 13, POS_PROGRAMMABLE_FIR_STAGE = 14;
	localparam int POS_IFMODE = 0, POS_CHAN = 4, POS_GAIN = 0, POS_TAPS = 2;

	localparam logic [2:0]  FRONT_HALVERS = 3'h4;
	localparam logic [2:0]  FRONT_FIVE    = 3'h5;
	localparam logic [1:0]  DEC_BY_TWO    = 2'h2;
	localparam logic [2:0]  PROGRAMMABLE_FIR_STAGE_BY_TWO   = 3'h2;
	localparam logic [2:0]  PROGRAMMABLE_FIR_STAGE_BY_FOUR  = 3'h4;
	localparam logic [3:0]  CH_NONE       = 4'h0;
	localparam logic [3:0]  CH_FIRST_OBS  = 4'h5;
	localparam logic [3:0]  CH_LAST       = 4'hA;
	localparam logic [19:0] RATE_MIN_KHZ  = 20'h0_7800;
	localparam logic [19:0] RATE_MAX_KHZ  = 20'h5_A000;
	localparam logic [2:0]  DIVIDE_BY_FIVE_DECIMATOR_LAST     = 3'h4;
	localparam logic signed [27:0] DIVIDE_BY_FIVE_DECIMATOR_SCALE = 28'h000_00CD;

	localparam cfg_t CFG_RESET = '{
		front_sel: FRONT_HALVERS, second_fixed_fir_dec: 2'h1, first_fixed_fir_dec: 2'h1, hb3_dec: 2'h1,
		hb2_dec: 2'h1, hb1_dec: 2'h1, hb1_wide: 1'b0, programmable_fir_stage_dec: 3'h1,
		programmable_fir_stage_gain: 2'h1, programmable_fir_stage_taps: 2'h0, if_mode: IFM_BYPASS, real_if: 1'b0,
		dual_band: 1'b0, chan_sel: CH_NONE, shift_steps: 8'h00,
		out_rate: 20'h0_7800};

	// Half-sum of two samples, used as the pairwise filter of every halving stage.
	function automatic sample_t avg2(input sample_t a, input sample_t b);
		logic signed [16:0] si;
		logic signed [16:0] sq;
		si = 17'(a.i) + 17'(b.i);
		sq = 17'(a.q) + 17'(b.q);
		avg2.i = si[16:1];
		avg2.q = sq[16:1];
	endfunction : avg2

	// Rotation by a multiple of a quarter turn: a shift of 0, +1/4, 1/2 or -1/4 of the rate.
	function automatic sample_t rot90(input sample_t s, input logic [1:0] ph);
		unique case (ph)
			2'h0: rot90 = s;
			2'h1: rot90 = '{i: -s.q, q: s.i};
			2'h2: rot90 = '{i: -s.i, q: -s.q};
			2'h3: rot90 = '{i: s.q, q: -s.i};
		endcase
	endfunction : rot90

	function automatic logic is_obs(input logic [3:0] chan);
		is_obs = (chan >= CH_FIRST_OBS);
	endfunction : is_obs

endpackage : rx_chain_pkg

// *** verilog/rx_decimation_if_conversion.sv ***
// Receive decimation chain, programmable FIR stage and dual-band IF conversion.
// Assumes ADC samples synchronous to clk and a register master on a plain strobe port.
`timescale 1ns/1ps
module rx_decimation_if_conversion
	import rx_chain_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire sample_t     adc_in,
	input  wire logic        adc_valid,
	output sample_t          link_out,
	output logic             link_valid,
	output logic      [3:0]  link_chan,
	output logic             link_real
);
	cfg_t        cfg_q, cfg_d;
	logic        run_q, run_d;
	logic [31:0] rdata_q, rdata_d;
	logic        rate_err_q, rate_err_d;
	logic        taps_err_q, taps_err_d;
	logic [2:0]  proc_div_q, proc_div_d;
	logic [31:0] count_q, count_d;
	logic [2:0]  dec_log2;
	logic [4:0]  dec_ratio;

	////////////////////////////////////////////////////////////////////////////////
	// Register port.
	always_comb
	begin
		cfg_d   = cfg_q;
		run_d   = run_q;
		rdata_d = 32'h0000_0000;
		if (reg_wr && reg_addr == ADDR_CTRL)
			run_d = reg_wdata[POS_RUN];
		if (reg_wr && !run_q)
		begin
			unique case (reg_addr)
				ADDR_CTRL:
				begin
					cfg_d.dual_band = reg_wdata[POS_DUAL];
					cfg_d.real_if   = reg_wdata[POS_REAL];
				end
				ADDR_DECIM:
				begin
					cfg_d.front_sel = reg_wdata[POS_FRONT +: 3];
					cfg_d.second_fixed_fir_dec  = reg_wdata[POS_SECOND_FIXED_FIR +: 2];
					cfg_d.first_fixed_fir_dec  = reg_wdata[POS_FIRST_FIXED_FIR +: 2];
					cfg_d.hb3_dec   = reg_wdata[POS_HB3 +: 2];
					cfg_d.hb2_dec   = reg_wdata[POS_HB2 +: 2];
					cfg_d.hb1_dec   = reg_wdata[POS_HB1 +: 2];
					cfg_d.hb1_wide  = reg_wdata[POS_WIDE];
					cfg_d.programmable_fir_stage_dec  = reg_wdata[POS_PROGRAMMABLE_FIR_STAGE +: 3];
				end
				ADDR_MODE:
				begin
					cfg_d.if_mode  = if_mode_t'(reg_wdata[POS_IFMODE +: 2]);
					cfg_d.chan_sel = reg_wdata[POS_CHAN +: 4];
				end
				ADDR_SHIFT: cfg_d.shift_steps = reg_wdata[7:0];
				ADDR_RATE:  cfg_d.out_rate = reg_wdata[19:0];
				ADDR_PROGRAMMABLE_FIR_STAGE:
				begin
					cfg_d.programmable_fir_stage_gain = reg_wdata[POS_GAIN +: 2];
					cfg_d.programmable_fir_stage_taps = reg_wdata[POS_TAPS +: 2];
				end
				default: ;
			endcase
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				ADDR_CTRL:   rdata_d = {29'h0, cfg_q.real_if, cfg_q.dual_band, run_q};
				ADDR_DECIM:  rdata_d = {15'h0, cfg_q.programmable_fir_stage_dec, cfg_q.hb1_wide, cfg_q.hb1_dec,
					cfg_q.hb2_dec, cfg_q.hb3_dec, cfg_q.first_fixed_fir_dec, cfg_q.second_fixed_fir_dec,
					cfg_q.front_sel};
				ADDR_MODE:   rdata_d = {24'h0, cfg_q.chan_sel, 2'h0, cfg_q.if_mode};
				ADDR_SHIFT:  rdata_d = {24'h0, cfg_q.shift_steps};
				ADDR_RATE:   rdata_d = {12'h0, cfg_q.out_rate};
				ADDR_PROGRAMMABLE_FIR_STAGE:   rdata_d = {28'h0, cfg_q.programmable_fir_stage_taps, cfg_q.programmable_fir_stage_gain};
				ADDR_STATUS: rdata_d = {26'h0, run_q, proc_div_q, taps_err_q, rate_err_q};
				ADDR_COUNT:  rdata_d = count_q;
				default:     rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Status: rate window, tap budget and processing-clock divider.
	always_comb
	begin
		dec_log2 = {2'h0, cfg_q.hb2_dec == DEC_BY_TWO} + {2'h0, cfg_q.hb1_dec == DEC_BY_TWO}
			+ ((cfg_q.programmable_fir_stage_dec == PROGRAMMABLE_FIR_STAGE_BY_TWO) ? 3'h1 : 3'h0)
			+ ((cfg_q.programmable_fir_stage_dec == PROGRAMMABLE_FIR_STAGE_BY_FOUR) ? 3'h2 : 3'h0);
		dec_ratio = 5'(5'h01 << dec_log2);
		rate_err_d = (cfg_q.out_rate < RATE_MIN_KHZ) || (cfg_q.out_rate > RATE_MAX_KHZ);
		// taps need 24 per unit of rate ratio
		taps_err_d = (cfg_q.programmable_fir_stage_taps == 2'h3) || ({3'h0, cfg_q.programmable_fir_stage_taps} >= dec_ratio);
		proc_div_d = (cfg_q.front_sel == FRONT_FIVE) ? 3'h5 : 3'h4;
		count_d = link_valid ? count_q + 32'h0000_0001 : count_q;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			cfg_q      <= CFG_RESET;
			run_q      <= 1'b0;
			rdata_q    <= 32'h0000_0000;
			rate_err_q <= 1'b0;
			taps_err_q <= 1'b0;
			proc_div_q <= 3'h4;
			count_q    <= 32'h0000_0000;
		end
		else
		begin
			cfg_q      <= cfg_d;
			run_q      <= run_d;
			rdata_q    <= rdata_d;
			rate_err_q <= rate_err_d;
			taps_err_q <= taps_err_d;
			proc_div_q <= proc_div_d;
			count_q    <= count_d;
		end
	end

	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Front divide-by-five decimator.
	logic signed [18:0] acc_i_q, acc_i_d, acc_q_q, acc_q_d;
	logic        [2:0]  cnt5_q, cnt5_d;
	sample_t            d5_q, d5_d;
	logic               d5v_q, d5v_d;
	logic               front5;

	function automatic logic signed [15:0] scale5(input logic signed [18:0] s);
		logic signed [27:0] p;
		p = 28'(s) * DIVIDE_BY_FIVE_DECIMATOR_SCALE;
		scale5 = p[25:10];
	endfunction : scale5

	always_comb
	begin
		front5  = (cfg_q.front_sel == FRONT_FIVE);
		acc_i_d = acc_i_q;
		acc_q_d = acc_q_q;
		cnt5_d  = cnt5_q;
		d5_d    = d5_q;
		d5v_d   = 1'b0;
		if (adc_valid && front5 && run_q)
		begin
			if (cnt5_q == DIVIDE_BY_FIVE_DECIMATOR_LAST)
			begin
				d5_d.i  = scale5(acc_i_q + 19'(adc_in.i));
				d5_d.q  = scale5(acc_q_q + 19'(adc_in.q));
				d5v_d   = 1'b1;
				acc_i_d = '0;
				acc_q_d = '0;
				cnt5_d  = 3'h0;
			end
			else
			begin
				acc_i_d = acc_i_q + 19'(adc_in.i);
				acc_q_d = acc_q_q + 19'(adc_in.q);
				cnt5_d  = cnt5_q + 3'h1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			acc_i_q <= '0;
			acc_q_q <= '0;
			cnt5_q  <= 3'h0;
			d5_q    <= '0;
			d5v_q   <= 1'b0;
		end
		else
		begin
			acc_i_q <= acc_i_d;
			acc_q_q <= acc_q_d;
			cnt5_q  <= cnt5_d;
			d5_q    <= d5_d;
			d5v_q   <= d5v_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Halving chain: fixed FIR two, fixed FIR one, half-bands three, two, one, FIR x2 x2.
	logic    [6:0] byp, nar;
	sample_t       st_in [7];
	sample_t       st_out [7];
	logic    [6:0] st_iv, st_ov;

	always_comb
	begin
		// fixed FIR two ignored for observation
		byp[0] = (cfg_q.second_fixed_fir_dec != DEC_BY_TWO) || is_obs(cfg_q.chan_sel);
		byp[1] = (cfg_q.first_fixed_fir_dec != DEC_BY_TWO);
		byp[2] = (cfg_q.hb3_dec != DEC_BY_TWO);
		byp[3] = (cfg_q.hb2_dec != DEC_BY_TWO);
		byp[4] = (cfg_q.hb1_dec != DEC_BY_TWO);
		// FIR decimation 1, 2 or 4
		byp[5] = (cfg_q.programmable_fir_stage_dec != PROGRAMMABLE_FIR_STAGE_BY_TWO) && (cfg_q.programmable_fir_stage_dec != PROGRAMMABLE_FIR_STAGE_BY_FOUR);
		byp[6] = (cfg_q.programmable_fir_stage_dec != PROGRAMMABLE_FIR_STAGE_BY_FOUR);
		nar    = {2'h0, !cfg_q.hb1_wide && !is_obs(cfg_q.chan_sel), 4'h0};
	end

	for (genvar k = 0; k < 7; k++)
	begin : chain_g
		if (k == 0)
		begin : head_g
			assign st_in[k] = adc_in;
			assign st_iv[k] = adc_valid && !front5 && run_q;
		end
		else if (k == 3)
		begin : join_g
			assign st_in[k] = front5 ? d5_q : st_out[k-1];
			assign st_iv[k] = front5 ? d5v_q : st_ov[k-1];
		end
		else
		begin : link_g
			assign st_in[k] = st_out[k-1];
			assign st_iv[k] = st_ov[k-1];
		end
		decim2_stage stage_u (
			.clk       (clk),
			.reset_n   (reset_n),
			.bypass    (byp[k]),
			.narrow    (nar[k]),
			.in_s      (st_in[k]),
			.in_valid  (st_iv[k]),
			.out_s     (st_out[k]),
			.out_valid (st_ov[k])
		);
	end

	// FIR gain block; its output stream is the profile rate.
	sample_t pf_q, pf_d;
	logic    pfv_q;

	function automatic logic signed [15:0] gain(input logic signed [15:0] x,
		input logic [1:0] g);
		unique case (g)
			2'h0: gain = x <<< 1;
			2'h1: gain = x;
			2'h2: gain = x >>> 1;
			2'h3: gain = x >>> 2;
		endcase
	endfunction : gain

	always_comb
	begin
		pf_d.i = gain(st_out[6].i, cfg_q.programmable_fir_stage_gain);
		pf_d.q = gain(st_out[6].q, cfg_q.programmable_fir_stage_gain);
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			pf_q  <= '0;
			pfv_q <= 1'b0;
		end
		else
		begin
			pf_q  <= pf_d;
			pfv_q <= st_ov[6];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// IF conversion: two band paths of shift, interpolate, half-band, decimate, shift.
	// two band paths
	for (genvar b = 0; b < 2; b++)
	begin : band_g
		logic [1:0] ph1_q, ph1_d, ph2_q, ph2_d;
		sample_t    r1_q, r1_d, ip_q, ip_d, prev_q, prev_d, hb_q, hb_d, r2_q, r2_d;
		logic       r1v_q, r1v_d, ipv_q, ipv_d, pend_q, pend_d, hbv_q, hbv_d;
		logic       dph_q, dph_d, r2v_q, r2v_d, en;

		// each band shifts the shared FIR output by its own steps
		always_comb
		begin
			en     = (b == 0) || cfg_q.dual_band;
			ph1_d  = ph1_q;
			ph2_d  = ph2_q;
			r1_d   = r1_q;
			r1v_d  = pfv_q && en;
			if (pfv_q && en)
			begin
				r1_d  = rot90(pf_q, ph1_q);
				ph1_d = ph1_q + cfg_q.shift_steps[b*4 +: 2];
			end
			ip_d   = r1v_q ? r1_q : ip_q;
			ipv_d  = r1v_q || pend_q;
			pend_d = r1v_q && (cfg_q.if_mode == IFM_INT2);
			prev_d = ipv_q ? ip_q : prev_q;
			hb_d   = !ipv_q ? hb_q :
				(cfg_q.if_mode == IFM_BYPASS) ? ip_q : avg2(prev_q, ip_q);
			hbv_d  = ipv_q;
			dph_d  = dph_q;
			r2_d   = r2_q;
			r2v_d  = 1'b0;
			if (hbv_q)
			begin
				dph_d = (cfg_q.if_mode == IFM_DEC2) ? !dph_q : 1'b0;
				if (!dph_q || cfg_q.if_mode != IFM_DEC2)
				begin
					r2_d  = rot90(hb_q, ph2_q);
					r2v_d = 1'b1;
					ph2_d = ph2_q + cfg_q.shift_steps[b*4+2 +: 2];
				end
			end
		end

		always_ff @(posedge clk)
		begin
			if (!reset_n)
			begin
				ph1_q  <= 2'h0;
				ph2_q  <= 2'h0;
				r1_q   <= '0;
				ip_q   <= '0;
				prev_q <= '0;
				hb_q   <= '0;
				r2_q   <= '0;
				r1v_q  <= 1'b0;
				ipv_q  <= 1'b0;
				pend_q <= 1'b0;
				hbv_q  <= 1'b0;
				dph_q  <= 1'b0;
				r2v_q  <= 1'b0;
			end
			else
			begin
				ph1_q  <= ph1_d;
				ph2_q  <= ph2_d;
				r1_q   <= r1_d;
				ip_q   <= ip_d;
				prev_q <= prev_d;
				hb_q   <= hb_d;
				r2_q   <= r2_d;
				r1v_q  <= r1v_d;
				ipv_q  <= ipv_d;
				pend_q <= pend_d;
				hbv_q  <= hbv_d;
				dph_q  <= dph_d;
				r2v_q  <= r2v_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link output.
	sample_t    out_q, out_d;
	logic       ov_q, ov_d, real_q;
	logic [3:0] chan_q;

	always_comb
	begin
		out_d = cfg_q.dual_band ? avg2(band_g[0].r2_q, band_g[1].r2_q) : band_g[0].r2_q;
		if (cfg_q.real_if)
			out_d.q = 16'h0000;
		ov_d = band_g[0].r2v_q && (cfg_q.chan_sel != CH_NONE) && (cfg_q.chan_sel <= CH_LAST);
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			out_q  <= '0;
			ov_q   <= 1'b0;
			real_q <= 1'b0;
			chan_q <= CH_NONE;
		end
		else
		begin
			out_q  <= ov_d ? out_d : out_q;
			ov_q   <= ov_d;
			real_q <= cfg_q.real_if;
			chan_q <= cfg_q.chan_sel;
		end
	end

	assign link_out   = out_q;
	assign link_valid = ov_q;
	assign link_chan  = chan_q;
	assign link_real  = real_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_real_drops_q: assert property (link_valid && link_real |-> link_out.q == 16'h0000)
		else $error("quadrature sent in real mode");
	a_no_chan_quiet: assert property (cfg_q.chan_sel == CH_NONE |=> !link_valid)
		else $error("output with no channel selected");
	a_cfg_frozen: assert property (run_q && $past(run_q) |-> $stable(cfg_q))
		else $error("settings changed while running");
	a_rate_window: assert property ($stable(cfg_q.out_rate) |-> rate_err_q
		== (cfg_q.out_rate < RATE_MIN_KHZ || cfg_q.out_rate > RATE_MAX_KHZ))
		else $error("rate flag wrong");
	a_div_follows: assert property (cfg_q.front_sel == FRONT_FIVE ##1 $stable(cfg_q)
		|=> proc_div_q == 3'h5)
		else $error("divider not five");
	a_obs_second_fixed_fir: assert property (is_obs(cfg_q.chan_sel) |-> byp[0] && !nar[4])
		else $error("observation profile uses fixed FIR two");
	a_programmable_fir_stage_one: assert property (cfg_q.programmable_fir_stage_dec == 3'h1 |-> byp[5] && byp[6])
		else $error("FIR factor 1 not bypassed");
	a_read_slot: assert property (reg_rd && reg_addr == ADDR_COUNT |=>
		reg_rdata == $past(count_q))
		else $error("read data late");
	a_no_read_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data outside slot");
	a_taps_budget: assert property (cfg_q.programmable_fir_stage_taps == 2'h2 && dec_ratio < 5'h3 |=> taps_err_q)
		else $error("tap budget not flagged");
endmodule : rx_decimation_if_conversion
